// ===== rtl/psp_ctrl.sv
// Design decisions made here: the register addresses and register access over AHB-Lite.
`include "psp_defines.svh"

module psp_ctrl #(
  parameter int unsigned RAMP_CYCLES =
    `PSP_RAMP_TIME_MS * `PSP_NS_PER_MS / `PSP_CLK_PERIOD_NS
) (
  // clock and reset
  input  wire logic        sys_clk_in,
  input  wire logic        sys_rst_in,
  // ahb-lite slave
  input  wire logic        hsel_in,
  input  wire logic [31:0] haddr_in,
  input  wire logic [1:0]  htrans_in,
  input  wire logic        hwrite_in,
  input  wire logic [2:0]  hsize_in,
  input  wire logic [31:0] hwdata_in,
  input  wire logic        hready_in,
  output logic      [31:0] hrdata_out,
  output logic             hreadyout_out,
  output logic             hresp_out,
  // pins from the modulator and controller
  input  wire logic [3:0]  pwm_in,
  input  wire logic        stage_reset_n_in,
  // analog detector flags
  input  wire logic [3:0]  overcurrent_hs_in,
  input  wire logic [3:0]  overcurrent_ls_in,
  input  wire logic        temp_warn_in,
  input  wire logic        temp_shut_in,
  input  wire logic        logic_supply_ok_in,
  input  wire logic [1:0]  gate_drive_supply_ok_in,
  input  wire logic [3:0]  bootstrap_low_in,
  // half-bridge drive
  output logic      [3:0]  hb_pwm_out,
  output logic      [3:0]  hb_en_out,
  output logic      [3:0]  pulldown_en_out,
  // status pins
  output logic             thermal_warning_out,
  output logic             fault_alert_out,
  output logic             fault_alert_oe_n_out
);

  localparam int unsigned STEP_CYCLES_I = RAMP_CYCLES / `PSP_RAMP_MAX;
  localparam logic [19:0] STEP_LAST =
    (STEP_CYCLES_I > 1) ? 20'(STEP_CYCLES_I - 1) : 20'h0;

  function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] offs);
    reg_hit = (addr == offs);
  endfunction : reg_hit

  // synchronised inputs
  logic [3:0] pwm_s;
  logic       rst_s;
  logic [3:0] cur_hs_s;
  logic [3:0] cur_ls_s;
  logic       warn_s;
  logic       shut_s;
  logic       logic_ok_s;
  logic [1:0] gate_ok_s;
  logic [3:0] boot_low_s;

  psp_sync #(.W(`PSP_SYNC_W)) u_sync (
    .sys_clk_in (sys_clk_in),
    .async_in   ({pwm_in, stage_reset_n_in, overcurrent_hs_in, overcurrent_ls_in,
                  temp_warn_in, temp_shut_in, logic_supply_ok_in,
                  gate_drive_supply_ok_in, bootstrap_low_in}),
    .sync_out   ({pwm_s, rst_s, cur_hs_s, cur_ls_s, warn_s, shut_s, logic_ok_s,
                  gate_ok_s, boot_low_s})
  );

  // registers
  logic [1:0]  mode_reg;
  logic [7:0]  ovl_limit_reg;
  logic [7:0]  addr_reg;
  logic        wr_pend_reg;
  logic [31:0] rdata_reg;
  logic [3:0]  pwm_prev_reg;
  logic        rst_prev_reg;
  logic [3:0]  limit_reg;
  logic [3:0]  limit_next;
  logic [7:0]  frame_cnt_reg;
  logic        frame_hit_reg;
  logic [7:0]  ovl_cnt_reg;
  logic        ovl_latch_reg;
  logic        therm_latch_reg;
  logic [7:0]  ramp_lvl_reg;
  logic [19:0] step_cnt_reg;
  psp_pkg::psp_state_e state_reg;
  psp_pkg::psp_state_e state_next;

  logic [3:0] cur_s;
  logic [3:0] pwm_rise;
  logic       rst_rise;
  logic       supply_low;
  logic       boot_low;
  logic       ovl_set;
  logic       therm_set;
  logic       shut_now;
  logic       single_mode;
  logic       step_tick;
  logic       ramp_pass;
  logic       addr_ok;

  assign cur_s       = cur_hs_s | cur_ls_s;
  assign pwm_rise    = pwm_s & ~pwm_prev_reg;
  assign rst_rise    = rst_s & ~rst_prev_reg;
  assign supply_low  = ~(logic_ok_s & (&gate_ok_s));
  assign boot_low    = |boot_low_s;
  assign single_mode = (mode_reg == psp_pkg::PSP_MODE_SINGLE);
  assign step_tick   = (step_cnt_reg == STEP_LAST);
  assign ramp_pass   = (ramp_lvl_reg == `PSP_RAMP_MAX) || (frame_cnt_reg < ramp_lvl_reg);

  // ahb-lite: zero wait state, always okay
  assign addr_ok       = hsel_in && hready_in && htrans_in[1];
  assign hreadyout_out = 1'b1;
  assign hresp_out     = 1'b0;
  assign hrdata_out    = rdata_reg;

  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      addr_reg    <= 8'h00;
      wr_pend_reg <= 1'b0;
      rdata_reg   <= 32'h0;
    end else begin
      wr_pend_reg <= addr_ok && hwrite_in;
      if (addr_ok) begin
        addr_reg <= haddr_in[7:0];
      end
      if (addr_ok && !hwrite_in) begin
        if (reg_hit(haddr_in[7:0], `PSP_ADDR_CTRL)) begin
          rdata_reg <= {30'h0, mode_reg};
        end else if (reg_hit(haddr_in[7:0], `PSP_ADDR_STATUS)) begin
          rdata_reg <= {16'h0, ramp_lvl_reg, 2'h0, hb_en_out[0], warn_s,
                        boot_low, supply_low, therm_latch_reg, ovl_latch_reg};
        end else if (reg_hit(haddr_in[7:0], `PSP_ADDR_CONFIG)) begin
          rdata_reg <= {24'h0, ovl_limit_reg};
        end else begin
          rdata_reg <= 32'h0;
        end
      end
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      mode_reg      <= `PSP_MODE_RST;
      ovl_limit_reg <= `PSP_OVL_LIMIT_RST;
    end else if (wr_pend_reg) begin
      if (reg_hit(addr_reg, `PSP_ADDR_CTRL)) begin
        mode_reg <= hwdata_in[1:0];
      end
      if (reg_hit(addr_reg, `PSP_ADDR_CONFIG)) begin
        ovl_limit_reg <= hwdata_in[7:0];
      end
    end
  end

  // edge history
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      pwm_prev_reg <= 4'h0;
      rst_prev_reg <= 1'b1;
    end else begin
      pwm_prev_reg <= pwm_s;
      rst_prev_reg <= rst_s;
    end
  end

  // cycle-by-cycle current limit, released on next pwm rise
  always_comb begin
    limit_next = (limit_reg & ~pwm_rise) | cur_s;
  end

  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      limit_reg <= 4'h0;
    end else begin
      limit_reg <= limit_next;
    end
  end

  // frame counter and overload persistence
  assign ovl_set = frame_hit_reg && (frame_cnt_reg == `PSP_FRAME_LAST)
                   && (ovl_cnt_reg + 8'h01 >= ovl_limit_reg);

  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      frame_cnt_reg <= 8'h00;
      frame_hit_reg <= 1'b0;
      ovl_cnt_reg   <= 8'h00;
    end else begin
      frame_cnt_reg <= frame_cnt_reg + 8'h01;
      if (frame_cnt_reg == `PSP_FRAME_LAST) begin
        frame_hit_reg <= |cur_s;
        ovl_cnt_reg   <= (frame_hit_reg && state_reg != psp_pkg::PSP_ST_OFF)
                         ? ovl_cnt_reg + 8'h01 : 8'h00;
      end else begin
        frame_hit_reg <= frame_hit_reg | (|cur_s);
      end
    end
  end

  // latched shutdowns; a set in the clearing cycle wins
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      ovl_latch_reg <= 1'b0;
    end else if (ovl_set) begin
      ovl_latch_reg <= 1'b1;
    end else if (rst_rise || supply_low) begin
      ovl_latch_reg <= 1'b0;
    end
  end

  assign therm_set = shut_s;

  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      therm_latch_reg <= 1'b0;
    end else if (therm_set) begin
      therm_latch_reg <= 1'b1;
    end else if (!rst_s) begin
      therm_latch_reg <= 1'b0;
    end
  end

  assign shut_now = ovl_set || ovl_latch_reg || therm_set || therm_latch_reg
                    || supply_low || boot_low;

  // power stage sequencing
  always_comb begin
    state_next = state_reg;
    if (shut_now) begin
      state_next = psp_pkg::PSP_ST_OFF;
    end else begin
      unique case (state_reg)
        psp_pkg::PSP_ST_OFF: begin
          if (rst_s) begin
            state_next = psp_pkg::PSP_ST_UP;
          end
        end
        psp_pkg::PSP_ST_UP: begin
          if (!rst_s) begin
            state_next = psp_pkg::PSP_ST_DOWN;
          end else if (ramp_lvl_reg == `PSP_RAMP_MAX) begin
            state_next = psp_pkg::PSP_ST_RUN;
          end
        end
        psp_pkg::PSP_ST_RUN: begin
          if (!rst_s) begin
            state_next = psp_pkg::PSP_ST_DOWN;
          end
        end
        psp_pkg::PSP_ST_DOWN: begin
          if (rst_s) begin
            state_next = psp_pkg::PSP_ST_UP;
          end else if (ramp_lvl_reg == `PSP_RAMP_MIN) begin
            state_next = psp_pkg::PSP_ST_OFF;
          end
        end
        default: begin
          state_next = psp_pkg::PSP_ST_OFF;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      state_reg <= psp_pkg::PSP_ST_OFF;
    end else begin
      state_reg <= state_next;
    end
  end

  // soft ramp timer; ramp only in bridged mode
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      step_cnt_reg <= 20'h0;
      ramp_lvl_reg <= `PSP_RAMP_MIN;
    end else begin
      step_cnt_reg <= step_tick ? 20'h0 : step_cnt_reg + 20'h1;
      if (state_reg == psp_pkg::PSP_ST_OFF) begin
        ramp_lvl_reg <= `PSP_RAMP_MIN;
      end else if (mode_reg != psp_pkg::PSP_MODE_BRIDGED) begin
        ramp_lvl_reg <= (state_reg == psp_pkg::PSP_ST_DOWN) ? `PSP_RAMP_MIN : `PSP_RAMP_MAX;
      end else if (step_tick) begin
        if (state_reg == psp_pkg::PSP_ST_UP && ramp_lvl_reg != `PSP_RAMP_MAX) begin
          ramp_lvl_reg <= ramp_lvl_reg + 8'h01;
        end else if (state_reg == psp_pkg::PSP_ST_DOWN && ramp_lvl_reg != `PSP_RAMP_MIN) begin
          ramp_lvl_reg <= ramp_lvl_reg - 8'h01;
        end
      end
    end
  end

  // output drive
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      hb_pwm_out      <= 4'h0;
      hb_en_out       <= 4'h0;
      pulldown_en_out <= 4'h0;
    end else begin
      hb_en_out       <= (state_next != psp_pkg::PSP_ST_OFF) ? 4'hf : 4'h0;
      hb_pwm_out      <= (state_next != psp_pkg::PSP_ST_OFF && ramp_pass)
                         ? (pwm_s & ~limit_next) : 4'h0;
      pulldown_en_out <= (!rst_s && !single_mode && state_next == psp_pkg::PSP_ST_OFF)
                         ? 4'hf : 4'h0;
    end
  end

  // warning and alert pins
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      thermal_warning_out  <= 1'b0;
      fault_alert_oe_n_out <= 1'b1;
    end else begin
      thermal_warning_out  <= warn_s;
      fault_alert_oe_n_out <= !(rst_s && shut_now);
    end
  end

  assign fault_alert_out = 1'b0;

  // checks
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (sys_rst_in);

  property p_boot;
    boot_low |=> hb_en_out == 4'h0 && state_reg == psp_pkg::PSP_ST_OFF;
  endproperty
  a_boot: assert property (p_boot) else $error("bootstrap low did not stop stage");

  property p_limit;
    cur_s[0] |=> !hb_pwm_out[0];
  endproperty
  a_limit: assert property (p_limit) else $error("current limit not applied");

  property p_ovl;
    ovl_set |=> ovl_latch_reg && hb_en_out == 4'h0;
  endproperty
  a_ovl: assert property (p_ovl) else $error("overload did not latch shutdown");

  property p_all_off;
    ovl_latch_reg |-> hb_en_out == 4'h0 && hb_pwm_out == 4'h0;
  endproperty
  a_all_off: assert property (p_all_off) else $error("half-bridge left on");

  property p_warn;
    warn_s != thermal_warning_out |=> thermal_warning_out == $past(warn_s);
  endproperty
  a_warn: assert property (p_warn) else $error("warning pin wrong");

  property p_therm;
    shut_s && rst_s |=> therm_latch_reg && hb_en_out == 4'h0 && !fault_alert_oe_n_out;
  endproperty
  a_therm: assert property (p_therm) else $error("thermal shutdown missing");

  property p_therm_hold;
    therm_latch_reg && rst_s |=> therm_latch_reg;
  endproperty
  a_therm_hold: assert property (p_therm_hold) else $error("thermal latch lost");

  property p_por;
    supply_low && !ovl_set |=> !ovl_latch_reg;
  endproperty
  a_por: assert property (p_por) else $error("overload not cleared");

  property p_uv;
    supply_low && rst_s |=> hb_en_out == 4'h0 && !fault_alert_oe_n_out;
  endproperty
  a_uv: assert property (p_uv) else $error("undervoltage not handled");

  property p_auto;
    state_reg == psp_pkg::PSP_ST_OFF && rst_s && !shut_now
      |=> state_reg == psp_pkg::PSP_ST_UP;
  endproperty
  a_auto: assert property (p_auto) else $error("no restart");

  property p_mute;
    !rst_s && state_reg == psp_pkg::PSP_ST_OFF |=> hb_en_out == 4'h0;
  endproperty
  a_mute: assert property (p_mute) else $error("reset did not mute");

  property p_pulldown;
    !rst_s |=> pulldown_en_out == ($past(single_mode) || hb_en_out != 4'h0 ? 4'h0 : 4'hf);
  endproperty
  a_pulldown: assert property (p_pulldown) else $error("pulldown wrong");

  property p_alert_rst;
    !rst_s |=> fault_alert_oe_n_out;
  endproperty
  a_alert_rst: assert property (p_alert_rst) else $error("alert not forced high");

  property p_clear;
    rst_rise && !ovl_set |=> !ovl_latch_reg;
  endproperty
  a_clear: assert property (p_clear) else $error("overload not cleared on reset");

  property p_ramp;
    state_reg == psp_pkg::PSP_ST_UP && !shut_now && rst_s |=> ramp_lvl_reg >= $past(ramp_lvl_reg);
  endproperty
  a_ramp: assert property (p_ramp) else $error("ramp went backwards");

  property p_alert;
    rst_s && shut_now |=> !fault_alert_oe_n_out;
  endproperty
  a_alert: assert property (p_alert) else $error("alert not driven");

  c_run:   cover property (state_reg == psp_pkg::PSP_ST_RUN);
  c_down:  cover property (state_reg == psp_pkg::PSP_ST_DOWN ##1 state_reg == psp_pkg::PSP_ST_OFF);
  c_ovl:   cover property (ovl_set);
  c_therm: cover property (therm_latch_reg ##1 !rst_s);

endmodule : psp_ctrl

// ===== common/psp_defines.svh
// How it works
// - bootstrap undervoltage flag shuts the outputs down
// - overcurrent on a half-bridge cuts its pulse for the rest of the frame
// - overcurrent persisting over many frames sets a latched Hi-Z shutdown
// - an overload on any half-bridge shuts down all four together
// - thermal warning output follows the 125 C detector
// - above 150 C: thermal shutdown latch, all outputs Hi-Z, alert low
// - thermal shutdown latch holds until reset is asserted, then resumes
// - power-on clear resets overload guard and holds stage off until supplies good
// - any supply below threshold: outputs Hi-Z at once, alert low
// - after undervoltage the stage restarts by itself, no reset needed
// - reset low holds all four half-bridges in Hi-Z once the ramp down has ended
// - reset low enables weak pulldowns in bridged modes, never in single-ended
// - reset low forces the shutdown alert inactive high
// - reset rising edge clears a latched overload shutdown
// - in bridged mode duty cycle ramps between zero and input duty on reset transitions
// - alert is driven low whenever a fault has shut the stage down while reset is high
`ifndef PSP_DEFINES_SVH
`define PSP_DEFINES_SVH

`define PSP_CLK_PERIOD_NS  10
`define PSP_RAMP_TIME_MS   10
`define PSP_NS_PER_MS      1000000
`define PSP_ADDR_CTRL      8'h00
`define PSP_ADDR_STATUS    8'h04
`define PSP_ADDR_CONFIG    8'h08
`define PSP_MODE_RST       2'h0
`define PSP_OVL_LIMIT_RST  8'h08
`define PSP_RAMP_MAX       8'hff
`define PSP_RAMP_MIN       8'h00
`define PSP_FRAME_LAST     8'hff
`define PSP_SYNC_W         22

`endif

// ===== common/psp_pkg.sv
package psp_pkg;

  typedef enum logic [1:0] {
    PSP_MODE_BRIDGED = 2'h0,
    PSP_MODE_SINGLE  = 2'h1,
    PSP_MODE_THREE   = 2'h2
  } psp_mode_e;

  typedef enum logic [3:0] {
    PSP_ST_OFF  = 4'h1,
    PSP_ST_UP   = 4'h2,
    PSP_ST_RUN  = 4'h4,
    PSP_ST_DOWN = 4'h8
  } psp_state_e;

endpackage : psp_pkg

// ===== rtl/psp_sync.sv
module psp_sync #(
  parameter int W = 1
) (
  // clock
  input  wire logic         sys_clk_in,
  // async inputs
  input  wire logic [W-1:0] async_in,
  // synced outputs
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] meta_reg;
  logic [W-1:0] sync_reg;

  always_ff @(posedge sys_clk_in) begin
    meta_reg <= async_in;
    sync_reg <= meta_reg;
  end

  assign sync_out = sync_reg;

endmodule : psp_sync

// ===== sim/psp_partner.sv
module psp_partner #(
  parameter int FRAME   = 256,
  parameter int HOLDOFF = 64
) (
  // clock and reset
  input  wire logic       sys_clk_in,
  input  wire logic       sys_rst_in,
  // controller intent
  input  wire logic       run_req_in,
  input  wire logic [7:0] duty_in,
  input  wire logic       fault_alert_n_in,
  // pins toward the stage
  output logic      [3:0] pwm_out,
  output logic            stage_reset_n_out
);
  timeunit 1ns;
  timeprecision 100ps;

  localparam int DUTY_MAX = FRAME * 961 / 1000;

  int frame_cnt_reg;
  int hold_reg;
  int duty_lim;

  // modulation index capped, leaves a low gap in every frame
  assign duty_lim = (int'(duty_in) > DUTY_MAX) ? DUTY_MAX : int'(duty_in);

  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in || frame_cnt_reg == FRAME - 1) begin
      frame_cnt_reg <= 0;
    end else begin
      frame_cnt_reg <= frame_cnt_reg + 1;
    end
  end

  // switches in every frame unless duty_in is zero, also while the stage ramps down
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      pwm_out <= 4'h0;
    end else begin
      pwm_out <= (frame_cnt_reg < duty_lim) ? 4'hf : 4'h0;
    end
  end

  // no restart until the hold-off after a fault has run out
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in || !fault_alert_n_in) begin
      hold_reg <= HOLDOFF;
    end else if (hold_reg != 0) begin
      hold_reg <= hold_reg - 1;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in || !run_req_in) begin
      stage_reset_n_out <= 1'b0;
    end else if (hold_reg == 0) begin
      stage_reset_n_out <= 1'b1;
    end
  end
endmodule : psp_partner

// ===== sim/power_stage_protection_ctrl_tb_top.sv
module power_stage_protection_ctrl_tb_top;
  timeunit 1ns;
  timeprecision 100ps;

  logic        clk;
  logic        rst;
  logic        hsel;
  logic        hwrite;
  logic [1:0]  htrans;
  logic [31:0] haddr;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic [31:0] rdv;
  logic        hreadyout;
  logic        hresp;
  logic [3:0]  pwm;
  logic [3:0]  cur_hs;
  logic [3:0]  cur_ls;
  logic [3:0]  boot_low;
  logic [3:0]  hb_pwm;
  logic [3:0]  hb_en;
  logic [3:0]  pd_en;
  logic [1:0]  gate_ok;
  logic [7:0]  duty;
  logic        rst_n;
  logic        t_warn;
  logic        t_shut;
  logic        logic_ok;
  logic        warn;
  logic        alert;
  logic        alert_oe_n;
  logic        alert_n;
  logic        run_req;
  int          n_errors;
  int          samples_checked;

  // open-drain alert with pull-up
  assign alert_n = alert_oe_n ? 1'b1 : alert;

  always #5 clk = ~clk;

  psp_ctrl #(.RAMP_CYCLES(2550)) psp_ctrl_i (
    .sys_clk_in(clk), .sys_rst_in(rst), .hsel_in(hsel), .haddr_in(haddr),
    .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata),
    .hready_in(hreadyout), .hrdata_out(hrdata), .hreadyout_out(hreadyout),
    .hresp_out(hresp), .pwm_in(pwm), .stage_reset_n_in(rst_n),
    .overcurrent_hs_in(cur_hs), .overcurrent_ls_in(cur_ls), .temp_warn_in(t_warn),
    .temp_shut_in(t_shut), .logic_supply_ok_in(logic_ok),
    .gate_drive_supply_ok_in(gate_ok), .bootstrap_low_in(boot_low),
    .hb_pwm_out(hb_pwm), .hb_en_out(hb_en), .pulldown_en_out(pd_en),
    .thermal_warning_out(warn), .fault_alert_out(alert),
    .fault_alert_oe_n_out(alert_oe_n));

  psp_partner psp_partner_i (
    .sys_clk_in(clk), .sys_rst_in(rst), .run_req_in(run_req), .duty_in(duty),
    .fault_alert_n_in(alert_n), .pwm_out(pwm), .stage_reset_n_out(rst_n));

  task automatic close_out();
    $display("checks %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : close_out

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH at %0t: %s", $time, what);
    end
  endtask : check

  task automatic wait_en(input logic [3:0] exp, input int bound, input string what);
    int n;
    n = 0;
    while (hb_en !== exp && n < bound) begin
      @(negedge clk);
      n++;
    end
    check(hb_en, exp, what);
    if (n >= bound) begin
      close_out();
    end
  endtask : wait_en

  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    htrans <= 2'h2;
    hwrite <= wr;
    do begin
      @(posedge clk);
      n++;
    end while (hreadyout !== 1'b1 && n < 100);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do begin
      @(posedge clk);
      n++;
    end while (hreadyout !== 1'b1 && n < 100);
    rd = hrdata;
    check(hresp, 1'b0, "okay response");
    if (n >= 100) begin
      check(1'b0, 1'b1, "bus timeout");
      close_out();
    end
    @(negedge clk);
  endtask : ahb

  task automatic t_regs();
    ahb(1'b0, 8'h00, 32'h0, rdv);
    check(rdv, 32'h0, "ctrl reset value");
    ahb(1'b0, 8'h08, 32'h0, rdv);
    check(rdv, 32'h8, "config reset value");
    ahb(1'b1, 8'h10, 32'hffffffff, rdv);
    ahb(1'b0, 8'h10, 32'h0, rdv);
    check(rdv, 32'h0, "unmapped read");
    ahb(1'b1, 8'h00, 32'h2, rdv);
    ahb(1'b0, 8'h00, 32'h0, rdv);
    check(rdv, 32'h2, "ctrl write");
    ahb(1'b1, 8'h00, 32'h0, rdv);
    $display("done regs");
  endtask : t_regs

  task automatic wait_pwm(input logic lvl);
    int n;
    n = 0;
    while (pwm[0] !== lvl && n < 600) begin
      @(negedge clk);
      n++;
    end
    if (n >= 600) begin
      check(1'b0, 1'b1, "pwm wait timeout");
      close_out();
    end
  endtask : wait_pwm

  task automatic t_power_up();
    repeat (100) @(negedge clk);
    check(hb_en, 4'h0, "held off on low supply");
    check(alert_n, 1'b0, "alert on low supply");
    @(posedge clk);
    logic_ok <= 1'b1;
    gate_ok <= 2'h3;
    repeat (1000) @(negedge clk);
    ahb(1'b0, 8'h04, 32'h0, rdv);
    check(rdv[15:8] != 8'h00 && rdv[15:8] != 8'hff, 1'b1, "ramp midway");
    wait_en(4'hf, 4000, "stage starts");
    check(alert_n, 1'b1, "alert released");
    $display("done power_up");
  endtask : t_power_up

  task automatic t_warning();
    @(posedge clk);
    t_warn <= 1'b1;
    repeat (2) @(posedge clk);
    @(negedge clk);
    check(warn, 1'b0, "warning before sync");
    @(negedge clk);
    check(warn, 1'b1, "warning set");
    @(posedge clk);
    t_warn <= 1'b0;
    repeat (3) @(posedge clk);
    @(negedge clk);
    check(warn, 1'b0, "warning cleared");
    $display("done warning");
  endtask : t_warning

  task automatic t_auto_faults();
    for (int i = 0; i < 2; i++) begin
      @(posedge clk);
      if (i == 0) begin
        gate_ok <= 2'h1;
      end else begin
        boot_low <= 4'h2;
      end
      repeat (3) @(posedge clk);
      @(negedge clk);
      check(hb_en, 4'h0, "hi-z on supply or bootstrap low");
      check(alert_n, 1'b0, "alert on auto fault");
      @(posedge clk);
      gate_ok <= 2'h3;
      boot_low <= 4'h0;
      wait_en(4'hf, 4000, "auto restart");
    end
    $display("done auto_faults");
  endtask : t_auto_faults

  task automatic t_cycle_limit();
    repeat (3000) @(negedge clk);
    wait_pwm(1'b0);
    wait_pwm(1'b1);
    repeat (10) @(posedge clk);
    cur_hs <= 4'h1;
    @(posedge clk);
    cur_hs <= 4'h0;
    repeat (3) @(posedge clk);
    @(negedge clk);
    check(hb_pwm, 4'he, "pulse cut on one bridge");
    check(hb_en, 4'hf, "no shutdown on single cut");
    wait_pwm(1'b0);
    wait_pwm(1'b1);
    repeat (3) @(negedge clk);
    check(hb_pwm, 4'hf, "cut released on next pulse");
    $display("done cycle_limit");
  endtask : t_cycle_limit

  task automatic t_overload();
    ahb(1'b1, 8'h08, 32'h2, rdv);
    @(posedge clk);
    cur_ls <= 4'h4;
    wait_en(4'h0, 2000, "overload shuts all four");
    check(alert_n, 1'b0, "alert on overload");
    @(posedge clk);
    cur_ls <= 4'h0;
    repeat (600) @(negedge clk);
    check(hb_en, 4'h0, "overload stays latched");
    ahb(1'b0, 8'h04, 32'h0, rdv);
    check(rdv[0], 1'b1, "overload latch status");
    @(posedge clk);
    run_req <= 1'b0;
    repeat (8) @(negedge clk);
    check(alert_n, 1'b1, "alert forced high in reset");
    repeat (3000) @(negedge clk);
    check(pd_en, 4'hf, "pulldowns in bridged reset");
    @(posedge clk);
    run_req <= 1'b1;
    wait_en(4'hf, 4000, "resume after reset edge");
    ahb(1'b1, 8'h08, 32'h8, rdv);
    $display("done overload");
  endtask : t_overload

  task automatic t_mute();
    repeat (3000) @(negedge clk);
    @(posedge clk);
    run_req <= 1'b0;
    repeat (1000) @(negedge clk);
    ahb(1'b0, 8'h04, 32'h0, rdv);
    check(rdv[15:8] != 8'h00 && rdv[15:8] != 8'hff, 1'b1, "ramp down midway");
    wait_en(4'h0, 4000, "hard mute");
    check(pd_en, 4'hf, "pulldowns bridged");
    ahb(1'b1, 8'h00, 32'h1, rdv);
    @(posedge clk);
    run_req <= 1'b1;
    wait_en(4'hf, 4000, "single-ended start");
    @(posedge clk);
    run_req <= 1'b0;
    wait_en(4'h0, 10, "single-ended mute");
    check(pd_en, 4'h0, "no pulldowns single-ended");
    ahb(1'b1, 8'h00, 32'h0, rdv);
    @(posedge clk);
    run_req <= 1'b1;
    wait_en(4'hf, 4000, "bridged restart");
    $display("done mute");
  endtask : t_mute

  task automatic t_thermal();
    repeat (3000) @(negedge clk);
    @(posedge clk);
    t_shut <= 1'b1;
    repeat (3) @(posedge clk);
    @(negedge clk);
    check(hb_en, 4'h0, "thermal hi-z");
    check(alert_n, 1'b0, "thermal alert");
    @(posedge clk);
    t_shut <= 1'b0;
    repeat (100) @(negedge clk);
    check(hb_en, 4'h0, "thermal latched");
    ahb(1'b0, 8'h04, 32'h0, rdv);
    check(rdv[1], 1'b1, "thermal latch status");
    @(posedge clk);
    run_req <= 1'b0;
    repeat (8) @(negedge clk);
    check(alert_n, 1'b1, "alert forced high");
    repeat (100) @(negedge clk);
    @(posedge clk);
    run_req <= 1'b1;
    wait_en(4'hf, 4000, "resume after thermal reset");
    $display("done thermal");
  endtask : t_thermal

  initial begin
    clk = 1'b0;
    rst = 1'b1;
    hsel = 1'b0;
    hwrite = 1'b0;
    htrans = 2'h0;
    haddr = 32'h0;
    hwdata = 32'h0;
    cur_hs = 4'h0;
    cur_ls = 4'h0;
    boot_low = 4'h0;
    gate_ok = 2'h0;
    duty = 8'h80;
    t_warn = 1'b0;
    t_shut = 1'b0;
    logic_ok = 1'b0;
    run_req = 1'b1;
    n_errors = 0;
    samples_checked = 0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    t_regs();
    t_power_up();
    t_warning();
    t_auto_faults();
    t_cycle_limit();
    t_overload();
    t_mute();
    t_thermal();
    close_out();
  end
endmodule : power_stage_protection_ctrl_tb_top
